//--- hw/bmcs_regs.v
// control and status register bank of the battery monitor front end
//
// Contract
// RQ1: writing one clears status bit; zero keeps
// RQ2: sample ready latches, host only clears it
// RQ3: internal fault latches until host clears it
// RQ4: latch external alert pull-up when not driving
// RQ5: four fault flags latch until host clears
// RQ6: balance bits per cell, upper bits zero
// RQ7: load detected only while charge driver off
// RQ8: converter enable gates conversions and overvoltage
// RQ9: temperature source select steers result source
// RQ10: shutdown needs 00, then 01, then 10
// RQ11: bypass replaces all fault delays with 250ms
// RQ12: continuous mode runs counter, ignores single shot
// RQ13: single shot runs once, clears, sets ready
// RQ14: driver bits switch discharge and charge gates
// RQ15: range bit doubles overcurrent and short thresholds
// RQ16: short delay code picks 70-400 us
// RQ17: short threshold code picks threshold per range
// RQ18: host never writes reserved bits one; host model masks them only at 04 and 06, and the test writes status bit 6 one
// RQ19: overcurrent delay code picks 8-1280 ms
// RQ20: overcurrent threshold code picks threshold per range
// RQ21: read-only and unimplemented bits read zero
// RQ22: fault flags set only after qualified delay
`timescale 1ns/1ps
`include "bmcs_defs.vh"
module bmcs_regs #(
  parameter [31:0] SCD_D2_CYC = `BMCS_SCD_D2_US * `BMCS_CLK_MHZ,
  parameter [31:0] SCD_D3_CYC = `BMCS_SCD_D3_US * `BMCS_CLK_MHZ,
  parameter [31:0] OCD_D0_CYC = `BMCS_OCD_D0_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D1_CYC = `BMCS_OCD_D1_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D2_CYC = `BMCS_OCD_D2_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D3_CYC = `BMCS_OCD_D3_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D4_CYC = `BMCS_OCD_D4_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D5_CYC = `BMCS_OCD_D5_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D6_CYC = `BMCS_OCD_D6_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OCD_D7_CYC = `BMCS_OCD_D7_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] BYPASS_CYC = `BMCS_BYPASS_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] CC_CONV_CYC = `BMCS_CC_CONV_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] UV_DELAY_CYC = `BMCS_UV_DELAY_MS * `BMCS_CLK_MHZ * 1000,
  parameter [31:0] OV_DELAY_CYC = `BMCS_OV_DELAY_MS * `BMCS_CLK_MHZ * 1000
) (
  // clock, reset, enable
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  // register port from the serial link engine
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // analog front end sense inputs (asynchronous)
  input wire [7:0] sense_mv_in,
  input wire ov_cond_in,
  input wire uv_cond_in,
  input wire load_above_in,
  input wire internal_fault_in,
  // host interrupt line
  input wire alert_in,
  output reg alert_out,
  output reg alert_oe_out,
  // controls to the analog front end
  output reg [14:0] balance_enable_out,
  output reg adc_enable_out,
  output reg temp_source_out,
  output reg discharge_gate_out,
  output reg charge_gate_out,
  output reg cc_active_out,
  output reg shutdown_out
);

  localparam [31:0] SCD_D0_CYC = `BMCS_SCD_D0_US * `BMCS_CLK_MHZ;
  localparam [31:0] SCD_D1_CYC = `BMCS_SCD_D1_US * `BMCS_CLK_MHZ;

  // ****************************************
  // threshold tables
  // ****************************************
  function [7:0] scd_thr;
    input [2:0] code;
    input dbl;
    begin
      case (code)
        3'h0: scd_thr = dbl ? 8'd44 : 8'd22;
        3'h1: scd_thr = dbl ? 8'd67 : 8'd33;
        3'h2: scd_thr = dbl ? 8'd89 : 8'd44;
        3'h3: scd_thr = dbl ? 8'd111 : 8'd56;
        3'h4: scd_thr = dbl ? 8'd133 : 8'd67;
        3'h5: scd_thr = dbl ? 8'd155 : 8'd78;
        3'h6: scd_thr = dbl ? 8'd178 : 8'd89;
        default: scd_thr = dbl ? 8'd200 : 8'd100;
      endcase
    end
  endfunction

  function [7:0] ocd_thr;
    input [3:0] code;
    input dbl;
    begin
      case (code)
        4'h0: ocd_thr = dbl ? 8'd17 : 8'd8;
        4'h1: ocd_thr = dbl ? 8'd22 : 8'd11;
        4'h2: ocd_thr = dbl ? 8'd28 : 8'd14;
        4'h3: ocd_thr = dbl ? 8'd33 : 8'd17;
        4'h4: ocd_thr = dbl ? 8'd39 : 8'd19;
        4'h5: ocd_thr = dbl ? 8'd44 : 8'd22;
        4'h6: ocd_thr = dbl ? 8'd50 : 8'd25;
        4'h7: ocd_thr = dbl ? 8'd56 : 8'd28;
        4'h8: ocd_thr = dbl ? 8'd61 : 8'd31;
        4'h9: ocd_thr = dbl ? 8'd67 : 8'd33;
        4'ha: ocd_thr = dbl ? 8'd72 : 8'd36;
        4'hb: ocd_thr = dbl ? 8'd78 : 8'd39;
        4'hc: ocd_thr = dbl ? 8'd83 : 8'd42;
        4'hd: ocd_thr = dbl ? 8'd89 : 8'd44;
        4'he: ocd_thr = dbl ? 8'd94 : 8'd47;
        default: ocd_thr = dbl ? 8'd100 : 8'd50;
      endcase
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [12:0] sync_a;
  reg [12:0] sync_b;
  reg [7:0] fault_status;
  reg [4:0] bal_low;
  reg [4:0] bal_mid;
  reg [4:0] bal_high;
  reg adc_en;
  reg temp_sel;
  reg rsvd_a;
  reg key_a;
  reg key_b;
  reg key_armed;
  reg load_det;
  reg bypass;
  reg cc_cont;
  reg cc_shot;
  reg [2:0] rsvd_b;
  reg discharge_driver_on;
  reg charge_driver_on;
  reg range_dbl;
  reg rsvd_p1;
  reg [1:0] scd_d;
  reg [2:0] scd_t;
  reg [2:0] ocd_d;
  reg [3:0] ocd_t;
  reg [31:0] cc_cnt;
  reg [1:0] drv_hist;
  reg [31:0] scd_lim;
  reg [31:0] ocd_lim;
  reg [7:0] next_rdata;

  wire [7:0] sense_s = sync_b[12:5];
  wire ov_s = sync_b[4];
  wire uv_s = sync_b[3];
  wire load_s = sync_b[2];
  wire alert_s = sync_b[1];
  wire int_fault_s = sync_b[0];

  wire wr_fs = reg_wr_in && (reg_addr_in == `BMCS_ADDR_FAULT_STATUS);
  wire wr_ca = reg_wr_in && (reg_addr_in == `BMCS_ADDR_SYS_CTRL_A);
  wire wr_cb = reg_wr_in && (reg_addr_in == `BMCS_ADDR_SYS_CTRL_B);
  wire [1:0] key_new = {reg_wdata_in[`BMCS_CA_KEY_A], reg_wdata_in[`BMCS_CA_KEY_B]};

  // ****************************************
  // input synchronisers
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync_a <= 13'h0000;
      sync_b <= 13'h0000;
    end else if (ce_in) begin
      sync_a <= {sense_mv_in, ov_cond_in, uv_cond_in, load_above_in, alert_in, internal_fault_in};
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // fault qualification
  // ****************************************
  always @* begin
    case (scd_d)
      2'h0: scd_lim = SCD_D0_CYC; // RQ16
      2'h1: scd_lim = SCD_D1_CYC; // RQ16
      2'h2: scd_lim = SCD_D2_CYC; // RQ16
      default: scd_lim = SCD_D3_CYC; // RQ16
    endcase
    case (ocd_d)
      3'h0: ocd_lim = OCD_D0_CYC; // RQ19
      3'h1: ocd_lim = OCD_D1_CYC; // RQ19
      3'h2: ocd_lim = OCD_D2_CYC; // RQ19
      3'h3: ocd_lim = OCD_D3_CYC; // RQ19
      3'h4: ocd_lim = OCD_D4_CYC; // RQ19
      3'h5: ocd_lim = OCD_D5_CYC; // RQ19
      3'h6: ocd_lim = OCD_D6_CYC; // RQ19
      default: ocd_lim = OCD_D7_CYC; // RQ19
    endcase
  end

  // order matches fault_status bits 3..0: uv, ov, short, overcurrent
  wire [3:0] q_cond;
  wire [127:0] q_lim;
  wire [3:0] q_fire;
  assign q_cond[3] = uv_s;
  assign q_cond[2] = ov_s & adc_en; // RQ8
  assign q_cond[1] = sense_s >= scd_thr(scd_t, range_dbl); // RQ15 RQ17
  assign q_cond[0] = sense_s >= ocd_thr(ocd_t, range_dbl); // RQ15 RQ20
  assign q_lim[127:96] = bypass ? BYPASS_CYC : UV_DELAY_CYC; // RQ11
  assign q_lim[95:64] = bypass ? BYPASS_CYC : OV_DELAY_CYC; // RQ11
  assign q_lim[63:32] = bypass ? BYPASS_CYC : scd_lim; // RQ11
  assign q_lim[31:0] = bypass ? BYPASS_CYC : ocd_lim; // RQ11

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_qual
      bmcs_fault_qual u_qual (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .cond_in(q_cond[gi]),
        .limit_in(q_lim[gi*32+31:gi*32]),
        .fire_out(q_fire[gi])
      ); // RQ22
    end
  endgenerate

  // ****************************************
  // coulomb counter sequencing
  // ****************************************
  wire cc_run = cc_cont | cc_shot; // RQ12
  wire cc_end = cc_run && (cc_cnt == CC_CONV_CYC - 32'h0000_0001);
  wire shot_ok = wr_cb && reg_wdata_in[`BMCS_CB_CC_SHOT] && !reg_wdata_in[`BMCS_CB_CC_CONT]
                 && !fault_status[`BMCS_FS_CC_SAMPLE_READY]; // RQ13

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cc_cnt <= 32'h0000_0000;
    end else if (ce_in) begin
      if (!cc_run || cc_end) begin
        cc_cnt <= 32'h0000_0000; // RQ12
      end else begin
        cc_cnt <= cc_cnt + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // alert override detection
  // ****************************************
  // the pin echo lags our own drive through the synchroniser, so wait it out
  wire ovrd_det = alert_s && !alert_oe_out && (drv_hist == 2'b00); // RQ4

  // ****************************************
  // status flags
  // ****************************************
  wire [7:0] fs_set = {cc_end, 1'b0, int_fault_s, ovrd_det, q_fire};
  wire [7:0] fs_clr = wr_fs ? reg_wdata_in : 8'h00;

  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      fault_status <= `BMCS_RST_BYTE;
      drv_hist <= 2'b00;
    end else if (ce_in) begin
      // set wins over a clear in the same cycle; reserved bit stays zero
      fault_status <= ((fault_status & ~fs_clr) | fs_set) & 8'hbf; // RQ1 RQ2 RQ3 RQ5
      drv_hist <= {drv_hist[0], alert_oe_out};
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      bal_low <= `BMCS_RST_BAL;
      bal_mid <= `BMCS_RST_BAL;
      bal_high <= `BMCS_RST_BAL;
      adc_en <= 1'b0;
      temp_sel <= 1'b0;
      rsvd_a <= 1'b0;
      key_a <= 1'b0;
      key_b <= 1'b0;
      key_armed <= 1'b0;
      shutdown_out <= 1'b0;
      bypass <= 1'b0;
      cc_cont <= 1'b0;
      cc_shot <= 1'b0;
      rsvd_b <= 3'h0;
      discharge_driver_on <= 1'b0;
      charge_driver_on <= 1'b0;
      range_dbl <= 1'b0;
      rsvd_p1 <= 1'b0;
      scd_d <= 2'h0;
      scd_t <= 3'h0;
      ocd_d <= 3'h0;
      ocd_t <= 4'h0;
      load_det <= 1'b0;
    end else if (ce_in) begin
      load_det <= load_s & ~charge_driver_on; // RQ7
      if (reg_wr_in && reg_addr_in == `BMCS_ADDR_BAL_LOW) begin
        bal_low <= reg_wdata_in[4:0]; // RQ6
      end
      if (reg_wr_in && reg_addr_in == `BMCS_ADDR_BAL_MID) begin
        bal_mid <= reg_wdata_in[4:0]; // RQ6
      end
      if (reg_wr_in && reg_addr_in == `BMCS_ADDR_BAL_HIGH) begin
        bal_high <= reg_wdata_in[4:0]; // RQ6
      end
      if (wr_ca) begin
        adc_en <= reg_wdata_in[`BMCS_CA_ADC_EN];
        temp_sel <= reg_wdata_in[`BMCS_CA_TEMP_SEL];
        rsvd_a <= reg_wdata_in[`BMCS_CA_RSVD];
        key_a <= key_new[1];
        key_b <= key_new[0];
        if ({key_a, key_b} == 2'b00 && key_new == 2'b01) begin
          key_armed <= 1'b1; // RQ10
        end else if (key_armed && key_new == 2'b10) begin
          key_armed <= 1'b0;
          shutdown_out <= 1'b1; // RQ10
        end else begin
          key_armed <= 1'b0; // RQ10
        end
      end
      if (wr_cb) begin
        bypass <= reg_wdata_in[`BMCS_CB_BYPASS];
        cc_cont <= reg_wdata_in[`BMCS_CB_CC_CONT];
        rsvd_b <= reg_wdata_in[`BMCS_CB_RSVD_HI:`BMCS_CB_RSVD_LO];
        discharge_driver_on <= reg_wdata_in[`BMCS_CB_DISCHARGE_DRIVER_ON];
        charge_driver_on <= reg_wdata_in[`BMCS_CB_CHARGE_DRIVER_ON];
      end
      // a new valid trigger outranks completion of the previous one
      if (shot_ok) begin
        cc_shot <= 1'b1; // RQ13
      end else if (cc_end) begin
        cc_shot <= 1'b0; // RQ13
      end
      if (reg_wr_in && reg_addr_in == `BMCS_ADDR_SC_PROTECT) begin
        range_dbl <= reg_wdata_in[`BMCS_P1_RANGE];
        rsvd_p1 <= reg_wdata_in[`BMCS_P1_RSVD];
        scd_d <= reg_wdata_in[`BMCS_P1_SCD_D_HI:`BMCS_P1_SCD_D_LO];
        scd_t <= reg_wdata_in[`BMCS_P1_SCD_T_HI:0];
      end
      if (reg_wr_in && reg_addr_in == `BMCS_ADDR_OC_PROTECT) begin
        ocd_d <= reg_wdata_in[`BMCS_P2_OCD_D_HI:`BMCS_P2_OCD_D_LO];
        ocd_t <= reg_wdata_in[`BMCS_P2_OCD_T_HI:0];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always @* begin
    case (reg_addr_in)
      `BMCS_ADDR_FAULT_STATUS: next_rdata = fault_status;
      `BMCS_ADDR_BAL_LOW: next_rdata = {3'h0, bal_low}; // RQ6 RQ21
      `BMCS_ADDR_BAL_MID: next_rdata = {3'h0, bal_mid}; // RQ6 RQ21
      `BMCS_ADDR_BAL_HIGH: next_rdata = {3'h0, bal_high}; // RQ6 RQ21
      `BMCS_ADDR_SYS_CTRL_A: next_rdata = {load_det, 2'h0, adc_en, temp_sel, rsvd_a, key_a, key_b}; // RQ7 RQ21
      `BMCS_ADDR_SYS_CTRL_B: next_rdata = {bypass, cc_cont, cc_shot, rsvd_b, discharge_driver_on, charge_driver_on};
      `BMCS_ADDR_SC_PROTECT: next_rdata = {range_dbl, 1'b0, rsvd_p1, scd_d, scd_t}; // RQ21
      `BMCS_ADDR_OC_PROTECT: next_rdata = {1'b0, ocd_d, ocd_t}; // RQ21
      default: next_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      alert_out <= 1'b0;
      alert_oe_out <= 1'b0;
      balance_enable_out <= 15'h0000;
      adc_enable_out <= 1'b0;
      temp_source_out <= 1'b0;
      discharge_gate_out <= 1'b0;
      charge_gate_out <= 1'b0;
      cc_active_out <= 1'b0;
    end else if (ce_in) begin
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
      // line driven high while any flag is pending
      alert_out <= |fault_status;
      alert_oe_out <= |fault_status;
      balance_enable_out <= {bal_high, bal_mid, bal_low}; // RQ6
      adc_enable_out <= adc_en; // RQ8
      temp_source_out <= temp_sel; // RQ9
      discharge_gate_out <= discharge_driver_on; // RQ14
      charge_gate_out <= charge_driver_on; // RQ14
      cc_active_out <= cc_run; // RQ12 RQ13
    end
  end

endmodule // bmcs_regs

//--- hw/bmcs_defs.vh
// register offsets, field positions, reset values and timing figures of the battery monitor register bank
`ifndef BMCS_DEFS_VH
`define BMCS_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define BMCS_ADDR_FAULT_STATUS 8'h00
`define BMCS_ADDR_BAL_LOW 8'h01
`define BMCS_ADDR_BAL_MID 8'h02
`define BMCS_ADDR_BAL_HIGH 8'h03
`define BMCS_ADDR_SYS_CTRL_A 8'h04
`define BMCS_ADDR_SYS_CTRL_B 8'h05
`define BMCS_ADDR_SC_PROTECT 8'h06
`define BMCS_ADDR_OC_PROTECT 8'h07

// ****************************************
// field positions
// ****************************************
`define BMCS_FS_CC_SAMPLE_READY 7
`define BMCS_FS_RSVD 6
`define BMCS_FS_INT_FAULT 5
`define BMCS_FS_ALERT_OVRD 4
`define BMCS_FS_UV 3
`define BMCS_FS_OV 2
`define BMCS_FS_SCD 1
`define BMCS_FS_OCD 0
`define BMCS_CA_LOAD 7
`define BMCS_CA_ADC_EN 4
`define BMCS_CA_TEMP_SEL 3
`define BMCS_CA_RSVD 2
`define BMCS_CA_KEY_A 1
`define BMCS_CA_KEY_B 0
`define BMCS_CB_BYPASS 7
`define BMCS_CB_CC_CONT 6
`define BMCS_CB_CC_SHOT 5
`define BMCS_CB_RSVD_HI 4
`define BMCS_CB_RSVD_LO 2
`define BMCS_CB_DISCHARGE_DRIVER_ON 1
`define BMCS_CB_CHARGE_DRIVER_ON 0
`define BMCS_P1_RANGE 7
`define BMCS_P1_RSVD 5
`define BMCS_P1_SCD_D_HI 4
`define BMCS_P1_SCD_D_LO 3
`define BMCS_P1_SCD_T_HI 2
`define BMCS_P2_OCD_D_HI 6
`define BMCS_P2_OCD_D_LO 4
`define BMCS_P2_OCD_T_HI 3

// ****************************************
// reset values
// ****************************************
`define BMCS_RST_BYTE 8'h00
`define BMCS_RST_BAL 5'h00

// ****************************************
// timing
// ****************************************
`define BMCS_CLK_MHZ 40
`define BMCS_SCD_D0_US 70
`define BMCS_SCD_D1_US 100
`define BMCS_SCD_D2_US 200
`define BMCS_SCD_D3_US 400
`define BMCS_OCD_D0_MS 8
`define BMCS_OCD_D1_MS 20
`define BMCS_OCD_D2_MS 40
`define BMCS_OCD_D3_MS 80
`define BMCS_OCD_D4_MS 160
`define BMCS_OCD_D5_MS 320
`define BMCS_OCD_D6_MS 640
`define BMCS_OCD_D7_MS 1280
`define BMCS_BYPASS_MS 250
`define BMCS_CC_CONV_MS 250
`define BMCS_UV_DELAY_MS 1000
`define BMCS_OV_DELAY_MS 1000
`define BMCS_DRV_SETTLE 2

`endif

//--- hw/bmcs_fault_qual.v
// persistence qualifier: one pulse once a condition has held for a programmed number of cycles
`timescale 1ns/1ps
module bmcs_fault_qual (
  // clock and control
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  // condition and delay
  input wire cond_in,
  input wire [31:0] limit_in,
  // qualified event
  output reg fire_out
);

  reg [31:0] count;
  reg done;

  // ****************************************
  // persistence counter
  // ****************************************
  // one pulse per episode; condition must drop before it can fire again
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      count <= 32'h0000_0000;
      done <= 1'b0;
      fire_out <= 1'b0;
    end else if (ce_in) begin
      fire_out <= 1'b0;
      if (!cond_in) begin
        count <= 32'h0000_0000;
        done <= 1'b0;
      end else if (!done) begin
        if (count + 32'h0000_0001 >= limit_in) begin
          fire_out <= 1'b1;
          done <= 1'b1;
        end else begin
          count <= count + 32'h0000_0001;
        end
      end
    end
  end

endmodule // bmcs_fault_qual

//--- sim/bmcs_regs_chk.sv
// assertion checker of the battery monitor register bank
`timescale 1ns/1ps
module bmcs_regs_chk (
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  input wire ce_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // front end controls
  input wire alert_out,
  input wire alert_oe_out,
  input wire [14:0] balance_enable_out,
  input wire adc_enable_out,
  input wire temp_source_out,
  input wire discharge_gate_out,
  input wire charge_gate_out,
  input wire cc_active_out,
  input wire shutdown_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // last written controls, cycles since
  // ****
  // outputs judged only once quiet for 7 cycles, so latency choices stay free
  wire wr_ok = ce_in && reg_wr_in;
  wire rd_ok = ce_in && reg_rd_in;
  wire wr_a = wr_ok && reg_addr_in == 8'h04;
  wire wr_b = wr_ok && reg_addr_in == 8'h05;
  wire wr_bal = wr_ok && reg_addr_in >= 8'h01 && reg_addr_in <= 8'h03;
  wire sw_a = wr_a && reg_wdata_in[1:0] == 2'h2;
  logic [7:0] cap_a;
  logic [7:0] cap_b;
  logic [14:0] cap_bal;
  logic [2:0] q_a;
  logic [2:0] q_b;
  logic [2:0] q_bal;
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      cap_a <= 8'h00;
      cap_b <= 8'h00;
      cap_bal <= 15'h0000;
      q_a <= 3'h0;
      q_b <= 3'h0;
      q_bal <= 3'h0;
    end else begin
      q_a <= wr_a ? 3'h0 : q_a + {2'h0, q_a != 3'h7};
      q_b <= wr_b ? 3'h0 : q_b + {2'h0, q_b != 3'h7};
      q_bal <= wr_bal ? 3'h0 : q_bal + {2'h0, q_bal != 3'h7};
      if (wr_a) cap_a <= reg_wdata_in;
      if (wr_b) cap_b <= reg_wdata_in;
      if (wr_ok && reg_addr_in == 8'h01) cap_bal[4:0] <= reg_wdata_in[4:0];
      if (wr_ok && reg_addr_in == 8'h02) cap_bal[9:5] <= reg_wdata_in[4:0];
      if (wr_ok && reg_addr_in == 8'h03) cap_bal[14:10] <= reg_wdata_in[4:0];
    end
  end
  // ****
  // assertions
  // ****
  a_gate_follow_ctrl: assert property (q_b == 3'h7 && !shutdown_out |->
    discharge_gate_out == cap_b[1] && charge_gate_out == cap_b[0]) else $error("gate drive differs");
  a_adc_follow_ctrl: assert property (q_a == 3'h7 |-> adc_enable_out == cap_a[4])
    else $error("converter enable differs");
  a_temp_follow_ctrl: assert property (q_a == 3'h7 |-> temp_source_out == cap_a[3])
    else $error("temperature source differs");
  a_bal_follow_ctrl: assert property (q_bal == 3'h7 |-> balance_enable_out == cap_bal)
    else $error("balance enables differ");
  a_cc_cont_runs: assert property (q_b == 3'h7 && cap_b[6] |-> cc_active_out)
    else $error("counter idle in continuous mode");
  a_unmapped_read_zero: assert property (rd_ok && reg_addr_in > 8'h07 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_bal_upper_zero: assert property (rd_ok && reg_addr_in >= 8'h01 && reg_addr_in <= 8'h03 |=>
    reg_rdata_out[7:5] == 3'h0) else $error("balance upper bits not zero");
  a_ctrl_ro_zero: assert property (rd_ok && reg_addr_in == 8'h04 |=> reg_rdata_out[6:5] == 2'h0)
    else $error("control read-only bits not zero");
  a_status_rsvd_zero: assert property (rd_ok && reg_addr_in == 8'h00 |=> !reg_rdata_out[6])
    else $error("status reserved bit not zero");
  a_shut_sticky: assert property (shutdown_out |=> shutdown_out)
    else $error("shutdown dropped");
  a_shut_key_cause: assert property ($rose(shutdown_out) |-> $past(sw_a, 1) || $past(sw_a, 2) || $past(sw_a, 3))
    else $error("shutdown without second key write");
  a_alert_push_high: assert property (alert_oe_out |-> alert_out)
    else $error("alert driven low");
  c_shutdown: cover property ($rose(shutdown_out));
  c_alert: cover property ($rose(alert_oe_out));
  c_cc: cover property ($rose(cc_active_out));
endmodule // bmcs_regs_chk
bind bmcs_regs bmcs_regs_chk bmcs_regs_chk_i (.*);

//--- sim/bmcs_host_model.sv
// host controller model on the register port
`timescale 1ns/1ps
module bmcs_host_model (
  // clock
  input wire sys_clk_in,
  // register port
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  input wire [7:0] rdata_in
);
  // one-cycle strobes launched on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out <= a;
    wdata_out <= d & ((a == 8'h04) ? 8'hfb : (a == 8'h06) ? 8'hdf : 8'hff);
    wr_out <= 1'b1;
    @(negedge sys_clk_in);
    wr_out <= 1'b0;
  endtask
  // data is taken one edge after the edge that saw the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(negedge sys_clk_in);
    rd_out <= 1'b0;
    @(posedge sys_clk_in);
    #1 d = rdata_in;
  endtask
endmodule // bmcs_host_model

//--- sim/bmcs_regs_tb.sv
// self-checking testbench of the battery monitor register bank
`timescale 1ns/1ps
module bmcs_regs_tb;
  logic sys_clk_in;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [7:0] sense_mv_in = 8'h00;
  logic ov_cond_in = 1'b0;
  logic uv_cond_in = 1'b0;
  logic load_above_in = 1'b0;
  logic internal_fault_in = 1'b0;
  logic alert_in = 1'b0;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire reg_wr_in, reg_rd_in, alert_out, alert_oe_out, adc_enable_out, temp_source_out;
  wire discharge_gate_out, charge_gate_out, cc_active_out, shutdown_out;
  wire [14:0] balance_enable_out;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  bmcs_regs #(.OCD_D0_CYC(32'd20), .BYPASS_CYC(32'd30), .CC_CONV_CYC(32'd40), .UV_DELAY_CYC(32'd20),
    .OV_DELAY_CYC(32'd20)) bmcs_regs_i (.*);
  bmcs_host_model bmcs_host_model_i (.sys_clk_in, .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
    .wr_out(reg_wr_in), .rd_out(reg_rd_in), .rdata_in(reg_rdata_out));
  // ****
  // clock, timeout, helpers
  // ****
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // the short-circuit delays dominate the run, about 20000 cycles
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 45000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    logic [7:0] d;
    bmcs_host_model_i.rd(a, d);
    chk(d & m, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bmcs_host_model_i.wr(a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // bounded wait for status bits, then judge
  task automatic poll(input logic [7:0] m, input int lim);
    logic [7:0] d;
    int k;
    d = 8'h00;
    for (k = 0; k < lim && (d & m) !== m; k++) bmcs_host_model_i.rd(8'h00, d);
    chk(d & m, m);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset_map();
    int a;
    for (a = 0; a < 9; a++) rchk(a[7:0], 8'h00);
    wr(8'h08, 8'hff);
    rchk(8'h08, 8'h00);
    for (a = 1; a < 4; a++) wr(a[7:0], 8'hff);
    for (a = 1; a < 4; a++) rchk(a[7:0], 8'h1f);
    wr(8'h02, 8'h0a);
    rchk(8'h02, 8'h0a);
    idle(2);
    chk(balance_enable_out, 16'h7d5f);
    @(negedge sys_clk_in) ce_in = 1'b0;
    wr(8'h02, 8'h15);
    @(negedge sys_clk_in) ce_in = 1'b1;
    rchk(8'h02, 8'h0a);
  endtask
  task automatic t_ctrl_load();
    wr(8'h04, 8'hfc);
    rchk(8'h04, 8'h18);
    chk(adc_enable_out, 1'b1);
    chk(temp_source_out, 1'b1);
    wr(8'h04, 8'h10);
    rchk(8'h04, 8'h10);
    chk(temp_source_out, 1'b0);
    @(negedge sys_clk_in) load_above_in = 1'b1;
    wr(8'h05, 8'h02);
    idle(4);
    chk({discharge_gate_out, charge_gate_out}, 2'h2);
    rchk(8'h04, 8'h90);
    wr(8'h05, 8'h01);
    rchk(8'h04, 8'h10);
    chk({discharge_gate_out, charge_gate_out}, 2'h1);
    wr(8'h05, 8'h00);
    @(negedge sys_clk_in) load_above_in = 1'b0;
    idle(4);
    rchk(8'h04, 8'h10);
  endtask
  // overcurrent trips on the way, so only the short bit is judged until the clear
  task automatic t_short(input logic [7:0] cfg, input logic [7:0] thr, input int dly);
    wr(8'h06, cfg);
    rchk(8'h06, cfg);
    @(negedge sys_clk_in) sense_mv_in = thr - 8'h01;
    idle(dly + 200);
    rchk(8'h00, 8'h00, 8'h02);
    @(negedge sys_clk_in) sense_mv_in = thr;
    idle(dly - 100);
    rchk(8'h00, 8'h00, 8'h02);
    poll(8'h02, 100);
    @(negedge sys_clk_in) sense_mv_in = 8'h00;
    wr(8'h00, 8'hfd);
    rchk(8'h00, 8'h02);
    wr(8'h00, 8'h02);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_overcurrent();
    wr(8'h07, 8'h8f);
    rchk(8'h07, 8'h0f);
    @(negedge sys_clk_in) sense_mv_in = 8'd49;
    idle(60);
    rchk(8'h00, 8'h00);
    @(negedge sys_clk_in) sense_mv_in = 8'd50;
    poll(8'h01, 20);
    @(negedge sys_clk_in) sense_mv_in = 8'h00;
    wr(8'h00, 8'h01);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_events();
    @(negedge sys_clk_in) alert_in = 1'b1;
    poll(8'h10, 10);
    chk(alert_oe_out, 1'b1);
    @(negedge sys_clk_in) alert_in = 1'b0;
    wr(8'h00, 8'h10);
    @(negedge sys_clk_in) internal_fault_in = 1'b1;
    poll(8'h20, 10);
    @(negedge sys_clk_in) alert_in = 1'b1;
    idle(10);
    rchk(8'h00, 8'h00, 8'h10);
    @(negedge sys_clk_in) {alert_in, internal_fault_in} = 2'h0;
    idle(4);
    wr(8'h00, 8'h20);
    rchk(8'h00, 8'h00);
    @(negedge sys_clk_in) ov_cond_in = 1'b1;
    poll(8'h04, 20);
    @(negedge sys_clk_in) ov_cond_in = 1'b0;
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h00);
    @(negedge sys_clk_in) {ov_cond_in, uv_cond_in} = 2'h3;
    poll(8'h08, 20);
    idle(40);
    rchk(8'h00, 8'h08);
    @(negedge sys_clk_in) {ov_cond_in, uv_cond_in} = 2'h0;
    wr(8'h00, 8'h08);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_counter();
    wr(8'h05, 8'h20);
    idle(2);
    chk(cc_active_out, 1'b1);
    poll(8'h80, 40);
    rchk(8'h05, 8'h00);
    chk(cc_active_out, 1'b0);
    wr(8'h05, 8'h20);
    rchk(8'h05, 8'h00);
    wr(8'h00, 8'h00);
    rchk(8'h00, 8'h80);
    wr(8'h05, 8'h60);
    rchk(8'h05, 8'h40);
    idle(100);
    rchk(8'h00, 8'h80);
    wr(8'h05, 8'h00);
    idle(3);
    chk(cc_active_out, 1'b0);
    wr(8'h00, 8'h80);
    idle(100);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_shutdown();
    wr(8'h04, 8'h02);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h04, 8'h03);
    wr(8'h04, 8'h02);
    idle(3);
    chk(shutdown_out, 1'b0);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h04, 8'h02);
    idle(3);
    chk(shutdown_out, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in = 1'b0;
    t_reset_map();
    t_ctrl_load();
    t_short(8'h07, 8'd100, 2800);
    t_short(8'h87, 8'd200, 2800);
    t_short(8'h0b, 8'd56, 4000);
    t_overcurrent();
    t_events();
    t_counter();
    t_shutdown();
    close_out();
  end
endmodule // bmcs_regs_tb
